/* File: cgci_pkg.sv */
// cgci_pkg: register map, field positions, reset values and timing for the clock
// generator control block; assumes a 32-bit AXI4-Lite bus and a 25 MHz ref_clk.
// Contract
// - irq request when irq enable and fault set
// - irq enable settable only after monitor on
// - fault flag sets on inactive source clock
// - fault clears by read-set then write-zero
// - monitor on needs enables and stables set
// - fault flag holds monitor on forced one
// - monitor off when enable clear or stop without keep
// - source select one external, zero internal
// - select change needs target enable and stable
// - select forced by inactivity, enables, reset
// - internal enable clears only if select, monitor-off
// - internal enable forced on by monitor/select
// - internal stable from in-range indication
// - internal stable forced clear in listed cases
// - external enable clears only with select, monitor zero
// - external enable forced by monitor or select
// - external stable after 4096 external edges
// - external stable forced clear, count restarts
// - multiplier and trim writes blocked while monitoring
// - stage writes blocked while internal generator on
// - stop without keep halts all clocks
package cgci_pkg;
	localparam logic [7:0]  ADDR_CONTROL  = 8'h00;
	localparam logic [7:0]  ADDR_MULT     = 8'h04;
	localparam logic [7:0]  ADDR_TRIM     = 8'h08;
	localparam logic [7:0]  ADDR_DIVIDER  = 8'h0c;
	localparam logic [7:0]  ADDR_STAGE    = 8'h10;
	localparam logic [7:0]  ADDR_CONFIG   = 8'h14;
	localparam int          CTL_IRQ_EN    = 7;
	localparam int          CTL_FAULT     = 6;
	localparam int          CTL_MON_ON    = 5;
	localparam int          CTL_SEL_EXT   = 4;
	localparam int          CTL_INT_EN    = 3;
	localparam int          CTL_INT_STB   = 2;
	localparam int          CTL_EXT_EN    = 1;
	localparam int          CTL_EXT_STB   = 0;
	localparam int          CFG_KEEP_STOP = 0;
	localparam logic [6:0]  MULT_RESET    = 7'h15;
	localparam logic [7:0]  TRIM_RESET    = 8'h80;
	localparam logic [7:0]  STAGE_RESET   = 8'h00;
	localparam logic [3:0]  DIV_RESET     = 4'h0;
	localparam logic [12:0] EXT_STABLE_EDGES = 13'h1000;
	localparam int          CLK_PERIOD_NS = 40;
	localparam int          EXT_DEAD_NS   = 20000;
	localparam int          EXT_DEAD_CYC  = EXT_DEAD_NS / CLK_PERIOD_NS;
	localparam logic [9:0]  EXT_DEAD_CNT  = 10'(EXT_DEAD_CYC);
	localparam logic [1:0]  RESP_OKAY     = 2'h0;
	localparam logic [1:0]  RESP_SLVERR   = 2'h2;

	typedef struct packed {
		logic irqEn;
		logic fault;
		logic monOn;
		logic selExt;
		logic intEn;
		logic intStable;
		logic extEn;
		logic extStable;
	} cgci_ctrl_t;

	typedef enum logic [1:0] {
		WR_IDLE = 2'b01,
		WR_RESP = 2'b10
	} cgci_wstate_t;
endpackage

/* File: cgci_top.sv */
// cgci_top: control register interlocks, clock monitor and source select of the
// clock generator, reached over AXI4-Lite. External clock and alive/range levels
// arrive asynchronous; stop request and loop filter values come from ref_clk logic.
//
// Design decisions made here: the AXI4-Lite slave port and the register addresses.
`timescale 1ns/1ps
module cgci_top (
	input  wire logic        ref_clk,
	input  wire logic        rst,
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	input  wire logic        externalClk,
	input  wire logic        internalClkAlive,
	input  wire logic        internalInRange,
	input  wire logic        stopReq,
	input  wire logic [7:0]  loopStage,
	input  wire logic [3:0]  loopDivider,
	output logic             monIrq,
	output logic             oscSelExt,
	output logic             intGenEnable,
	output logic             extGenEnable,
	output logic             clocksHalted,
	output logic [6:0]       multiplier,
	output logic [7:0]       trim,
	output logic [7:0]       dcoStage,
	output logic [3:0]       dcoDivider
);
	cgci_pkg::cgci_ctrl_t   ctl_r;
	cgci_pkg::cgci_ctrl_t   ctl_nxt;
	cgci_pkg::cgci_wstate_t wState_r;
	logic [7:0]  awAddr_r;
	logic [31:0] wData_r;
	logic [3:0]  wStrb_r;
	logic        awHeld_r;
	logic        wHeld_r;
	logic        keepInStop_r;
	logic        faultArmed_r;
	logic        extMeta_r;
	logic        extSync_r;
	logic        extPrev_r;
	logic        aliveMeta_r;
	logic        aliveSync_r;
	logic        rangeMeta_r;
	logic        rangeSync_r;
	logic [12:0] extEdges_r;
	logic [9:0]  extIdle_r;
	logic        wrEn;
	logic        wrByte;
	logic [7:0]  wrVal;
	logic        stopNoKeep;
	logic        intInactive;
	logic        extInactive;
	logic        extEdge;

	function automatic logic isMapped(input logic [7:0] addr);
		isMapped = addr == cgci_pkg::ADDR_CONTROL || addr == cgci_pkg::ADDR_MULT ||
			addr == cgci_pkg::ADDR_TRIM || addr == cgci_pkg::ADDR_DIVIDER ||
			addr == cgci_pkg::ADDR_STAGE || addr == cgci_pkg::ADDR_CONFIG;
	endfunction

	function automatic logic wrHits(input logic [7:0] addr);
		wrHits = wrEn && wrByte && awAddr_r == addr;
	endfunction

	// external clock and analog status levels are asynchronous
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			extMeta_r   <= 1'b0;
			extSync_r   <= 1'b0;
			extPrev_r   <= 1'b0;
			aliveMeta_r <= 1'b0;
			aliveSync_r <= 1'b0;
			rangeMeta_r <= 1'b0;
			rangeSync_r <= 1'b0;
		end else begin
			extMeta_r   <= externalClk;
			extSync_r   <= extMeta_r;
			extPrev_r   <= extSync_r;
			aliveMeta_r <= internalClkAlive;
			aliveSync_r <= aliveMeta_r;
			rangeMeta_r <= internalInRange;
			rangeSync_r <= rangeMeta_r;
		end
	end

	assign extEdge     = extSync_r && !extPrev_r;
	assign stopNoKeep  = stopReq && !keepInStop_r;
	// the monitor judges only while it is on
	assign intInactive = ctl_r.monOn && !aliveSync_r;
	assign extInactive = ctl_r.monOn && extIdle_r >= cgci_pkg::EXT_DEAD_CNT;

	// cycles since the last external edge, for the monitor
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			extIdle_r <= '0;
		end else if (extEdge || !ctl_r.extEn) begin
			extIdle_r <= '0;
		end else if (extIdle_r < cgci_pkg::EXT_DEAD_CNT) begin
			extIdle_r <= extIdle_r + 10'h001;
		end
	end

	// start-up count of external edges since enable
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			extEdges_r <= '0;
		end else if (!ctl_r.extEn || extInactive || stopNoKeep) begin
			extEdges_r <= '0;
		end else if (extEdge && extEdges_r < cgci_pkg::EXT_STABLE_EDGES) begin
			extEdges_r <= extEdges_r + 13'h0001;
		end
	end

	// write channel: address and data taken in either order, then one response
	assign wrEn   = wState_r == cgci_pkg::WR_IDLE && awHeld_r && wHeld_r;
	assign wrByte = wStrb_r[0];
	assign wrVal  = wData_r[7:0];

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			awHeld_r      <= 1'b0;
			awAddr_r      <= '0;
			s_axi_awready <= 1'b0;
		end else if (s_axi_awvalid && s_axi_awready) begin
			awHeld_r      <= 1'b1;
			awAddr_r      <= s_axi_awaddr;
			s_axi_awready <= 1'b0;
		end else if (wState_r == cgci_pkg::WR_RESP && s_axi_bready) begin
			awHeld_r      <= 1'b0;
		end else begin
			s_axi_awready <= !awHeld_r && wState_r == cgci_pkg::WR_IDLE;
		end
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			wHeld_r      <= 1'b0;
			wData_r      <= '0;
			wStrb_r      <= '0;
			s_axi_wready <= 1'b0;
		end else if (s_axi_wvalid && s_axi_wready) begin
			wHeld_r      <= 1'b1;
			wData_r      <= s_axi_wdata;
			wStrb_r      <= s_axi_wstrb;
			s_axi_wready <= 1'b0;
		end else if (wState_r == cgci_pkg::WR_RESP && s_axi_bready) begin
			wHeld_r      <= 1'b0;
		end else begin
			s_axi_wready <= !wHeld_r && wState_r == cgci_pkg::WR_IDLE;
		end
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			wState_r     <= cgci_pkg::WR_IDLE;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= cgci_pkg::RESP_OKAY;
		end else begin
			unique case (wState_r)
				cgci_pkg::WR_IDLE: begin
					if (wrEn) begin
						wState_r     <= cgci_pkg::WR_RESP;
						s_axi_bvalid <= 1'b1;
						s_axi_bresp  <= isMapped(awAddr_r) ? cgci_pkg::RESP_OKAY
							: cgci_pkg::RESP_SLVERR;
					end
				end
				cgci_pkg::WR_RESP: begin
					if (s_axi_bready) begin
						wState_r     <= cgci_pkg::WR_IDLE;
						s_axi_bvalid <= 1'b0;
					end
				end
				default: begin
					wState_r     <= cgci_pkg::WR_IDLE;
					s_axi_bvalid <= 1'b0;
				end
			endcase
		end
	end

	// read channel: one read at a time, data from current register state
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= '0;
			s_axi_rresp   <= cgci_pkg::RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b1;
			s_axi_rresp   <= isMapped(s_axi_araddr) ? cgci_pkg::RESP_OKAY
				: cgci_pkg::RESP_SLVERR;
			unique case (s_axi_araddr)
				cgci_pkg::ADDR_CONTROL: s_axi_rdata <= {24'h000000, ctl_r};
				cgci_pkg::ADDR_MULT:    s_axi_rdata <= {25'h0000000, multiplier};
				cgci_pkg::ADDR_TRIM:    s_axi_rdata <= {24'h000000, trim};
				cgci_pkg::ADDR_DIVIDER: s_axi_rdata <= {28'h0000000, dcoDivider};
				cgci_pkg::ADDR_STAGE:   s_axi_rdata <= {24'h000000, dcoStage};
				cgci_pkg::ADDR_CONFIG:  s_axi_rdata <= {31'h00000000, keepInStop_r};
				default:                s_axi_rdata <= '0;
			endcase
		end else if (s_axi_rvalid) begin
			if (s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end else begin
			s_axi_arready <= 1'b1;
		end
	end

	// a read that sees the fault set arms its clearing write
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			faultArmed_r <= 1'b0;
		end else if (!ctl_r.fault) begin
			faultArmed_r <= 1'b0;
		end else if (s_axi_arvalid && s_axi_arready &&
				s_axi_araddr == cgci_pkg::ADDR_CONTROL) begin
			faultArmed_r <= 1'b1;
		end
	end

	// control interlocks: software request first, forced conditions override
	always_comb begin
		logic       wrCtl;
		logic [7:0] req;
		wrCtl   = wrHits(cgci_pkg::ADDR_CONTROL);
		req     = ctl_r;
		ctl_nxt = ctl_r;
		if (wrCtl) begin
			req = wrVal;
		end

		// monitor on
		if (req[cgci_pkg::CTL_MON_ON] && ctl_r.intEn && ctl_r.extEn &&
				ctl_r.intStable && ctl_r.extStable) begin
			ctl_nxt.monOn = 1'b1;
		end else if (!req[cgci_pkg::CTL_MON_ON]) begin
			ctl_nxt.monOn = 1'b0;
		end
		if (ctl_r.fault) begin
			ctl_nxt.monOn = 1'b1;
		end
		if (!ctl_r.intEn || !ctl_r.extEn || stopNoKeep) begin
			ctl_nxt.monOn = 1'b0;
		end

		// irq enable
		ctl_nxt.irqEn = req[cgci_pkg::CTL_IRQ_EN] && ctl_r.monOn;

		// fault flag: set beats the clearing write
		if (wrCtl && faultArmed_r && !wrVal[cgci_pkg::CTL_FAULT]) begin
			ctl_nxt.fault = 1'b0;
		end
		if (intInactive || extInactive) begin
			ctl_nxt.fault = 1'b1;
		end
		if (!ctl_r.monOn) begin
			ctl_nxt.fault = 1'b0;
		end

		// source select
		if (req[cgci_pkg::CTL_SEL_EXT] && ctl_r.extEn && ctl_r.extStable) begin
			ctl_nxt.selExt = 1'b1;
		end else if (!req[cgci_pkg::CTL_SEL_EXT] && ctl_r.intEn && ctl_r.intStable) begin
			ctl_nxt.selExt = 1'b0;
		end
		if (intInactive || !ctl_r.intEn) begin
			ctl_nxt.selExt = 1'b1;
		end
		if (extInactive || !ctl_r.extEn) begin
			ctl_nxt.selExt = 1'b0;
		end

		// internal generator enable
		if (req[cgci_pkg::CTL_INT_EN]) begin
			ctl_nxt.intEn = 1'b1;
		end else if (ctl_r.selExt && !ctl_r.monOn) begin
			ctl_nxt.intEn = 1'b0;
		end
		if (ctl_r.monOn || !ctl_r.selExt) begin
			ctl_nxt.intEn = 1'b1;
		end

		// external generator enable
		if (req[cgci_pkg::CTL_EXT_EN]) begin
			ctl_nxt.extEn = 1'b1;
		end else if (!ctl_r.selExt && !ctl_r.monOn) begin
			ctl_nxt.extEn = 1'b0;
		end
		if (ctl_r.monOn || ctl_r.selExt) begin
			ctl_nxt.extEn = 1'b1;
		end

		// stable indications, read-only
		ctl_nxt.intStable = rangeSync_r;
		if (intInactive || !ctl_r.intEn || stopNoKeep ||
				(wrHits(cgci_pkg::ADDR_MULT) && !ctl_r.monOn) ||
				(wrHits(cgci_pkg::ADDR_TRIM) && !ctl_r.monOn)) begin
			ctl_nxt.intStable = 1'b0;
		end
		ctl_nxt.extStable = extEdges_r >= cgci_pkg::EXT_STABLE_EDGES;
		if (extInactive || !ctl_r.extEn || stopNoKeep) begin
			ctl_nxt.extStable = 1'b0;
		end
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			ctl_r <= '{irqEn: 1'b0, fault: 1'b0, monOn: 1'b0, selExt: 1'b0,
				intEn: 1'b1, intStable: 1'b0, extEn: 1'b0, extStable: 1'b0};
		end else begin
			ctl_r <= ctl_nxt;
		end
	end

	// pin-facing copies of the control state
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			monIrq       <= 1'b0;
			oscSelExt    <= 1'b0;
			intGenEnable <= 1'b1;
			extGenEnable <= 1'b0;
			clocksHalted <= 1'b0;
		end else begin
			monIrq       <= ctl_nxt.irqEn && ctl_nxt.fault;
			oscSelExt    <= ctl_nxt.selExt;
			intGenEnable <= ctl_nxt.intEn;
			extGenEnable <= ctl_nxt.extEn;
			clocksHalted <= stopNoKeep;
		end
	end

	// multiplier and trim
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			multiplier <= cgci_pkg::MULT_RESET;
			trim       <= cgci_pkg::TRIM_RESET;
		end else if (!ctl_r.monOn) begin
			if (wrHits(cgci_pkg::ADDR_MULT)) begin
				multiplier <= wrVal[6:0];
			end
			if (wrHits(cgci_pkg::ADDR_TRIM)) begin
				trim <= wrVal;
			end
		end
	end

	// oscillator stage and divider: loop filter owns them while internal is on
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			dcoStage   <= cgci_pkg::STAGE_RESET;
			dcoDivider <= cgci_pkg::DIV_RESET;
		end else if (ctl_r.intEn) begin
			dcoStage   <= loopStage;
			dcoDivider <= loopDivider;
		end else begin
			if (wrHits(cgci_pkg::ADDR_STAGE)) begin
				dcoStage <= wrVal;
			end
			if (wrHits(cgci_pkg::ADDR_DIVIDER)) begin
				dcoDivider <= wrVal[3:0];
			end
		end
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			keepInStop_r <= 1'b0;
		end else if (wrHits(cgci_pkg::ADDR_CONFIG)) begin
			keepInStop_r <= wrVal[cgci_pkg::CFG_KEEP_STOP];
		end
	end
endmodule // cgci_top

/* File: cgci_top_chk.sv */
// cgci_top_chk: concurrent checks on the outputs of cgci_top
// assumes it is bound into cgci_top and sees only that module's ports
`timescale 1ns/1ps
module cgci_top_chk (
	input wire logic       ref_clk,
	input wire logic       rst,
	input wire logic       stopReq,
	input wire logic [7:0] loopStage,
	input wire logic [3:0] loopDivider,
	input wire logic       monIrq,
	input wire logic       oscSelExt,
	input wire logic       intGenEnable,
	input wire logic       extGenEnable,
	input wire logic       clocksHalted,
	input wire logic [6:0] multiplier,
	input wire logic [7:0] trim,
	input wire logic [7:0] dcoStage,
	input wire logic [3:0] dcoDivider
);
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (rst);

	a_reset_state: assert property (
		$past(rst) |-> !oscSelExt && intGenEnable && !extGenEnable
			&& multiplier == cgci_pkg::MULT_RESET && trim == cgci_pkg::TRIM_RESET)
		else $error("outputs differ from reset state");
	a_sel_ext_on: assert property (
		oscSelExt |-> extGenEnable)
		else $error("external select without external enable");
	a_int_forced: assert property (
		!oscSelExt |-> intGenEnable)
		else $error("internal select without internal enable");
	a_irq_enables: assert property (
		monIrq |-> intGenEnable && extGenEnable)
		else $error("irq while a generator is off");
	a_mult_locked: assert property (
		monIrq |=> $stable(multiplier) && $stable(trim))
		else $error("multiplier or trim changed while monitoring");
	a_stage_follow: assert property (
		intGenEnable ##1 intGenEnable |-> dcoStage == $past(loopStage))
		else $error("stage not following loop filter");
	a_div_follow: assert property (
		intGenEnable ##1 intGenEnable |-> dcoDivider == $past(loopDivider))
		else $error("divider not following loop filter");
	a_halt_cause: assert property (
		clocksHalted |-> $past(stopReq))
		else $error("clocks halted without stop request");
endmodule // cgci_top_chk

bind cgci_top cgci_top_chk cgci_top_chk_i (.ref_clk, .rst, .stopReq, .loopStage, .loopDivider,
	.monIrq, .oscSelExt, .intGenEnable, .extGenEnable, .clocksHalted, .multiplier, .trim,
	.dcoStage, .dcoDivider);

/* File: tb_cgci_top.sv */
// tb_cgci_top: self-checking bench for cgci_top driven over AXI4-Lite
// assumes cgci_pkg is compiled first and the checker is bound to the top
`timescale 1ns/1ps
module tb_cgci_top;
	logic        ref_clk, rst, externalClk, extRun;
	logic        internalClkAlive, internalInRange, stopReq;
	logic [7:0]  s_axi_awaddr, s_axi_araddr, loopStage, trim, dcoStage;
	logic [31:0] s_axi_wdata, s_axi_rdata;
	logic [3:0]  s_axi_wstrb, loopDivider, dcoDivider;
	logic [1:0]  s_axi_bresp, s_axi_rresp;
	logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
	logic        s_axi_rvalid, s_axi_rready, monIrq, oscSelExt;
	logic        intGenEnable, extGenEnable, clocksHalted;
	logic [6:0]  multiplier;
	logic [33:0] expQ[$];
	int          errTotal, cmpCount;

	cgci_top cgci_top_i (.ref_clk, .rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
		.s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
		.s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .externalClk, .internalClkAlive,
		.internalInRange, .stopReq, .loopStage, .loopDivider, .monIrq, .oscSelExt,
		.intGenEnable, .extGenEnable, .clocksHalted, .multiplier, .trim, .dcoStage, .dcoDivider);

	task automatic chk(input logic [33:0] got, input logic [33:0] exp);
		cmpCount++;
		if (got !== exp) begin
			errTotal++;
			$display("ERROR %0t got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic pchk(input logic got, input logic exp);
		@(negedge ref_clk);
		chk(34'(got), 34'(exp));
		@(posedge ref_clk);
	endtask

	task automatic stopTest;
		if (errTotal == 0 && cmpCount > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	// looks at a ready or valid a half cycle early, then returns on the edge
	task automatic smp(input int s, output logic t);
		@(negedge ref_clk);
		t = (s == 0) ? s_axi_bvalid : (s == 1) ? s_axi_arready : s_axi_rvalid;
		@(posedge ref_clk);
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d,
		input logic [1:0] r = cgci_pkg::RESP_OKAY);
		logic da, dw, ta, tw;
		da = 1'b0;
		dw = 1'b0;
		expQ.push_back({r, 32'h0});
		s_axi_awaddr <= a;
		s_axi_wdata <= {24'($urandom), d};
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		while (!(da && dw)) begin
			@(negedge ref_clk);
			ta = !da && s_axi_awready;
			tw = !dw && s_axi_wready;
			@(posedge ref_clk);
			if (ta)
				s_axi_awvalid <= 1'b0;
			if (tw)
				s_axi_wvalid <= 1'b0;
			da |= ta;
			dw |= tw;
		end
		do smp(0, ta); while (!ta);
		s_axi_bready <= 1'b0;
		// one edge between calls so bready is never lowered and raised in one step
		@(posedge ref_clk);
	endtask

	task automatic rd(input logic [7:0] a, input logic [7:0] e,
		input logic [1:0] r = cgci_pkg::RESP_OKAY);
		logic t;
		expQ.push_back({r, 24'h0, e});
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do smp(1, t); while (!t);
		s_axi_arvalid <= 1'b0;
		do smp(2, t); while (!t);
		s_axi_rready <= 1'b0;
		// one edge between calls so rready is never lowered and raised in one step
		@(posedge ref_clk);
	endtask

	task automatic wc(input logic [7:0] d);
		wr(cgci_pkg::ADDR_CONTROL, d);
	endtask

	task automatic rc(input logic [7:0] e);
		rd(cgci_pkg::ADDR_CONTROL, e);
	endtask

	// response checker: oldest expectation against each completed response
	always @(negedge ref_clk) begin
		if (s_axi_bvalid && s_axi_bready)
			chk({s_axi_bresp, 32'h0}, expQ.pop_front());
		if (s_axi_rvalid && s_axi_rready)
			chk({s_axi_rresp, s_axi_rdata}, expQ.pop_front());
	end

	initial begin
		ref_clk = 1'b0;
		forever #20 ref_clk = ~ref_clk;
	end

	// external clock stands still while extRun is low
	initial begin
		externalClk = 1'b0;
		forever #50 if (extRun) externalClk = ~externalClk;
	end

	initial begin
		repeat (40000) @(posedge ref_clk);
		errTotal++;
		stopTest();
	end

	initial begin
		void'($urandom(32'h9292));
		rst = 1'b1;
		extRun = 1'b1;
		internalClkAlive = 1'b1;
		internalInRange = 1'b1;
		stopReq = 1'b0;
		loopStage = 8'($urandom);
		loopDivider = 4'($urandom);
		{s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wvalid, s_axi_bready} = '0;
		{s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
		s_axi_wstrb = 4'hf;
		repeat (12) @(posedge ref_clk);
		rst <= 1'b0;
		repeat (4) @(posedge ref_clk);
		rc(8'h0c);
		pchk(oscSelExt, 1'b0);
		pchk(intGenEnable, 1'b1);
		pchk(extGenEnable, 1'b0);
		rd(cgci_pkg::ADDR_MULT, 8'h15);
		rd(cgci_pkg::ADDR_TRIM, 8'h80);
		wr(8'h18, 8'h00, cgci_pkg::RESP_SLVERR);
		rd(8'h18, 8'h00, cgci_pkg::RESP_SLVERR);
		wc(8'h38);
		rc(8'h0c);
		wc(8'h00);
		rc(8'h0c);
		wc(8'h0a);
		wc(8'h1a);
		rc(8'h0e);
		repeat (10400) @(posedge ref_clk);
		rc(8'h0f);
		wc(8'hab);
		rc(8'h2f);
		wc(8'hab);
		wc(8'ha9);
		rc(8'haf);
		pchk(extGenEnable, 1'b1);
		wr(cgci_pkg::ADDR_MULT, 8'h33);
		wr(cgci_pkg::ADDR_TRIM, 8'h11);
		wr(cgci_pkg::ADDR_STAGE, 8'h5a);
		rd(cgci_pkg::ADDR_MULT, 8'h15);
		rd(cgci_pkg::ADDR_TRIM, 8'h80);
		rd(cgci_pkg::ADDR_STAGE, loopStage);
		rd(cgci_pkg::ADDR_DIVIDER, {4'h0, loopDivider});
		extRun = 1'b0;
		repeat (600) @(posedge ref_clk);
		wc(8'h8b);
		rc(8'hee);
		pchk(monIrq, 1'b1);
		wr(cgci_pkg::ADDR_MULT, 8'h44);
		rd(cgci_pkg::ADDR_MULT, 8'h15);
		extRun = 1'b1;
		repeat (30) @(posedge ref_clk);
		wc(8'hab);
		rc(8'hae);
		pchk(monIrq, 1'b0);
		stopReq <= 1'b1;
		repeat (3) @(posedge ref_clk);
		pchk(clocksHalted, 1'b1);
		rc(8'h0a);
		wr(cgci_pkg::ADDR_MULT, 8'h22);
		rd(cgci_pkg::ADDR_MULT, 8'h22);
		// a write without the low byte lane enabled leaves the register alone
		s_axi_wstrb <= 4'he;
		wr(cgci_pkg::ADDR_MULT, 8'h55);
		s_axi_wstrb <= 4'hf;
		rd(cgci_pkg::ADDR_MULT, 8'h22);
		wc(8'h08);
		rc(8'h08);
		pchk(extGenEnable, 1'b0);
		stopReq <= 1'b0;
		wr(cgci_pkg::ADDR_CONFIG, 8'h01);
		stopReq <= 1'b1;
		repeat (3) @(posedge ref_clk);
		pchk(clocksHalted, 1'b0);
		stopReq <= 1'b0;
		wc(8'h0a);
		repeat (10400) @(posedge ref_clk);
		wc(8'h2b);
		wc(8'h3b);
		rc(8'h3f);
		pchk(oscSelExt, 1'b1);
		wc(8'h37);
		rc(8'h3f);
		internalClkAlive <= 1'b0;
		repeat (5) @(posedge ref_clk);
		rc(8'h7b);
		pchk(oscSelExt, 1'b1);
		stopTest();
	end
endmodule // tb_cgci_top
